// ===== shared/vsla_pkg.sv
// Shared constants and types for the vector step and line addresser.
package vsla_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_PIXOP = 8'h04;
  localparam logic [7:0] ADDR_DSTEP = 8'h08;
  localparam logic [7:0] ADDR_DIM1  = 8'h0c;
  localparam logic [7:0] ADDR_ERR   = 8'h10;
  localparam logic [7:0] ADDR_KAX   = 8'h14;
  localparam logic [7:0] ADDR_KDG   = 8'h18;
  localparam logic [7:0] ADDR_DSTXY = 8'h1c;
  localparam logic [7:0] ADDR_SRCXY = 8'h20;
  localparam logic [7:0] ADDR_PATXY = 8'h24;
  localparam logic [7:0] ADDR_MSKXY = 8'h28;

  // Coprocessor control register bits.
  localparam int CTRL_BUSY_BIT = 0;
  localparam int CTRL_DONE_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;

  // Pixel operation register fields and reset value.
  localparam int PIXOP_FN_LSB   = 0;
  localparam int PIXOP_RD_BIT   = 2;
  localparam int PIXOP_MODE_LSB = 4;
  localparam int PIXOP_OCT_LSB  = 8;
  localparam logic [31:0] PIXOP_MASK = 32'h0000_0737;
  localparam logic [31:0] PIXOP_RST  = 32'h0000_0000;

  // Function codes.
  localparam logic [1:0] FN_OTHER = 2'h0;
  localparam logic [1:0] FN_LINE  = 2'h1;
  localparam logic [1:0] FN_STEP  = 2'h2;

  // Drawing modes.
  localparam logic [1:0] MODE_NORMAL     = 2'h0;
  localparam logic [1:0] MODE_FIRST_NULL = 2'h1;
  localparam logic [1:0] MODE_LAST_NULL  = 2'h2;

  // Octant field bits.
  localparam int OCT_XS_BIT = 2;
  localparam int OCT_YS_BIT = 1;
  localparam int OCT_MJ_BIT = 0;

  // Step code fields.
  localparam int CODE_DIR_LSB = 5;
  localparam int CODE_MD_BIT  = 4;
  localparam int CODE_CNT_LSB = 0;
  localparam logic [7:0] CODE_STOP = 8'h00;

  // Other reset values.
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] HALF_RST = 16'h0000;

  // Move vector {move x, x negative, move y, y negative}.
  localparam logic [3:0] VEC_NONE = 4'h0;
  localparam logic [3:0] VEC_XINC = 4'h8;

  // Map indices for the pointer arrays.
  localparam int MAP_DST = 0;
  localparam int MAP_SRC = 1;
  localparam int MAP_PAT = 2;
  localparam int MAP_MSK = 3;
  localparam int NUM_MAPS = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STEP = 2'b01,
    ST_LINE = 2'b10
  } vsla_state_t;

endpackage

// ===== src/vsla_ptr_step.sv
// One X/Y pointer pair moved to a neighbouring pixel by a move vector.
module vsla_ptr_step
  import vsla_pkg::*;
(
  // Present pointer.
  input  wire logic [15:0] x,
  input  wire logic [15:0] y,
  // Move vector {move x, x negative, move y, y negative}.
  input  wire logic [3:0]  vec,
  // Pointer after the move.
  output logic      [15:0] next_x,
  output logic      [15:0] next_y
);

  // Each axis moves by one pixel at most; pointers wrap at 16 bits.
  assign next_x = vec[3] ? (vec[2] ? x - 16'h0001 : x + 16'h0001) : x;
  assign next_y = vec[1] ? (vec[0] ? y - 16'h0001 : y + 16'h0001) : y;

endmodule

// ===== src/vsla_top.sv
// Address stepping for step-code and line draw operations, APB slave.
//
// The implementer's own choices: the APB register port and the register addresses.
module vsla_top
  import vsla_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic             PREADY,
  output logic      [31:0] PRDATA,
  output logic             PSLVERR,
  // Status.
  output logic             BUSY,
  // Pixel address stream.
  output logic             PIX_VALID,
  output logic             PIX_DRAW,
  output logic      [15:0] DST_X,
  output logic      [15:0] DST_Y,
  output logic      [15:0] SRC_X,
  output logic      [15:0] SRC_Y,
  output logic      [15:0] PAT_X,
  output logic      [15:0] PAT_Y,
  output logic      [15:0] MSK_X,
  output logic      [15:0] MSK_Y
);

  // Byte lane merge of a write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Picks one step code out of the direction step word.
  function automatic logic [7:0] code_of(input logic [31:0] word,
                                         input logic [1:0]  idx);
    return word[8*idx +: 8];
  endfunction

  // Direction code to move vector; codes go round counter-clockwise, Y down.
  function automatic logic [3:0] dir_vec(input logic [2:0] dir);
    logic [3:0] v;
    unique case (dir)
      3'h0: v = 4'h8;
      3'h1: v = 4'hb;
      3'h2: v = 4'h3;
      3'h3: v = 4'hf;
      3'h4: v = 4'hc;
      3'h5: v = 4'he;
      3'h6: v = 4'h2;
      3'h7: v = 4'ha;
    endcase
    return v;
  endfunction

  // Octant and diagonal decision to move vector; major axis always moves.
  function automatic logic [3:0] line_vec(input logic [2:0] oct,
                                          input logic       diag);
    logic mj;
    mj = oct[OCT_MJ_BIT];
    return {~mj | diag, oct[OCT_XS_BIT], mj | diag, oct[OCT_YS_BIT]};
  endfunction

  // Lowest written byte lane, where a step run begins.
  function automatic logic [1:0] first_lane(input logic [3:0] strb);
    logic [1:0] idx;
    idx = 2'd3;
    for (int i = 3; i >= 0; i--) begin
      if (strb[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  vsla_state_t state;
  vsla_state_t next_state;

  logic [31:0] pixop;
  logic [31:0] dstep;
  logic [15:0] dim1;
  logic [15:0] err_term;
  logic [15:0] k_axial;
  logic [15:0] k_diag;
  logic        done_flag;
  logic        stop_flag;
  logic [1:0]  code_idx;
  logic [15:0] run_cnt;
  logic        first_pix;
  logic [15:0] ptr_x [NUM_MAPS];
  logic [15:0] ptr_y [NUM_MAPS];
  logic [15:0] step_x [NUM_MAPS];
  logic [15:0] step_y [NUM_MAPS];
  logic [3:0]  map_vec [NUM_MAPS];
  logic [15:0] pix_x [NUM_MAPS];
  logic [15:0] pix_y [NUM_MAPS];

  // Bus decode; writes other than control are held off while running so
  // software can never disturb pointers or parameters of a live operation.
  wire        busy_now  = (state != ST_IDLE);
  wire        addr_ctrl = (PADDR == ADDR_CTRL);
  wire        addr_hit  = (PADDR <= ADDR_MSKXY) && (PADDR[1:0] == 2'b00);
  wire        stall     = busy_now & PWRITE & ~addr_ctrl;
  wire        accept    = PSEL & PENABLE & ~PREADY & ~stall;
  wire        commit    = PSEL & PENABLE & PREADY & PWRITE & addr_hit;
  wire        wr_ctrl   = commit & addr_ctrl;
  wire        wr_pixop  = commit & (PADDR == ADDR_PIXOP);
  wire        wr_dstep  = commit & (PADDR == ADDR_DSTEP);
  wire [31:0] pixop_new = merge(pixop, PWDATA, PSTRB) & PIXOP_MASK;
  wire [31:0] dstep_new = merge(dstep, PWDATA, PSTRB);

  // Operation fields of the stored pixel operation.
  wire [1:0] fn_sel   = pixop[PIXOP_FN_LSB +: 2];
  wire       rd_draw  = pixop[PIXOP_RD_BIT];
  wire [1:0] draw_md  = pixop[PIXOP_MODE_LSB +: 2];
  wire [2:0] octant   = pixop[PIXOP_OCT_LSB +: 3];

  // Starts: a line from the pixel operation write, a step run only from a
  // top byte write with the step function already stored.
  wire start_line = wr_pixop & (pixop_new[PIXOP_FN_LSB +: 2] == FN_LINE);
  wire start_step = wr_dstep & PSTRB[3] & (fn_sel == FN_STEP);

  // Current step code fields.
  wire [7:0] code      = code_of(dstep, code_idx);
  wire [7:0] code_next = code_of(dstep, code_idx + 2'd1);
  wire [2:0] code_dir  = code[CODE_DIR_LSB +: 3];
  wire       code_md   = code[CODE_MD_BIT];
  wire [3:0] code_cnt  = code[CODE_CNT_LSB +: 4];
  wire       code_stop = (code == CODE_STOP);

  // End of the present run and of the whole operation.
  wire in_step   = (state == ST_STEP);
  wire in_line   = (state == ST_LINE);
  wire code_end  = (run_cnt[3:0] == code_cnt);
  wire word_end  = (code_idx == 2'd3) | (code_next == CODE_STOP);
  wire line_end  = (run_cnt == dim1);
  wire run_end   = in_step ? code_end : line_end;
  wire pix_last  = in_step ? (code_end & word_end) : line_end;
  wire pix_fire  = (in_step & ~code_stop) | in_line;
  wire op_finish = (in_step & (code_stop | (code_end & code_idx == 2'd3)))
                 | (in_line & line_end);

  // Null end pixels are still stepped over, only the write is suppressed.
  wire null_first = first_pix & (draw_md == MODE_FIRST_NULL);
  wire null_last  = pix_last & (draw_md == MODE_LAST_NULL);
  wire pix_draw   = (in_line | code_md) & ~null_first & ~null_last;

  // Line decision: a non-negative error term takes the diagonal step.
  wire       diag   = ~err_term[15];
  wire [3:0] fn_raw = in_line ? line_vec(octant, diag) : dir_vec(code_dir);

  // The function map stops on the last pixel of each run; the other map increments X
  // after every pixel, so it stays on the next free source or target cell.
  wire [3:0] fn_vec = (pix_fire & ~run_end) ? fn_raw : VEC_NONE;
  wire [3:0] xi_vec = pix_fire ? VEC_XINC : VEC_NONE;
  assign map_vec[MAP_DST] = rd_draw ? xi_vec : fn_vec;
  assign map_vec[MAP_SRC] = rd_draw ? fn_vec : xi_vec;
  assign map_vec[MAP_PAT] = map_vec[MAP_SRC];
  assign map_vec[MAP_MSK] = map_vec[MAP_DST];

  // Address decode of pointer registers per map; the mask pair is read only.
  wire [NUM_MAPS-1:0] ptr_wr;
  assign ptr_wr[MAP_DST] = commit & (PADDR == ADDR_DSTXY);
  assign ptr_wr[MAP_SRC] = commit & (PADDR == ADDR_SRCXY);
  assign ptr_wr[MAP_PAT] = commit & (PADDR == ADDR_PATXY);
  assign ptr_wr[MAP_MSK] = 1'b0;

  // Read data selection.
  wire [31:0] ctrl_word = {29'h0, stop_flag, done_flag, busy_now};
  wire [31:0] rd_mux =
      (PADDR == ADDR_CTRL)  ? ctrl_word :
      (PADDR == ADDR_PIXOP) ? pixop :
      (PADDR == ADDR_DSTEP) ? dstep :
      (PADDR == ADDR_DIM1)  ? {16'h0, dim1} :
      (PADDR == ADDR_ERR)   ? {16'h0, err_term} :
      (PADDR == ADDR_KAX)   ? {16'h0, k_axial} :
      (PADDR == ADDR_KDG)   ? {16'h0, k_diag} :
      (PADDR == ADDR_DSTXY) ? {ptr_y[MAP_DST], ptr_x[MAP_DST]} :
      (PADDR == ADDR_SRCXY) ? {ptr_y[MAP_SRC], ptr_x[MAP_SRC]} :
      (PADDR == ADDR_PATXY) ? {ptr_y[MAP_PAT], ptr_x[MAP_PAT]} :
      (PADDR == ADDR_MSKXY) ? {ptr_y[MAP_MSK], ptr_x[MAP_MSK]} :
      WORD_RST;

  // One wait state on every access not stalled by a running operation keeps the answer a registered output.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= WORD_RST;
    end else begin
      PREADY  <= accept;
      PSLVERR <= accept & ~addr_hit;
      PRDATA  <= (accept & ~PWRITE & addr_hit) ? rd_mux : WORD_RST;
    end
  end

  // Operation control registers.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pixop <= PIXOP_RST;
      dstep <= WORD_RST;
      dim1  <= HALF_RST;
    end else begin
      if (wr_pixop) begin
        pixop <= pixop_new;
      end
      if (wr_dstep) begin
        dstep <= dstep_new;
      end
      if (commit & (PADDR == ADDR_DIM1)) begin
        dim1 <= 16'(merge({16'h0, dim1}, PWDATA, PSTRB));
      end
    end
  end

  // Line constants; the error term walks by one constant per pixel.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      err_term <= HALF_RST;
      k_axial  <= HALF_RST;
      k_diag   <= HALF_RST;
    end else begin
      if (commit & (PADDR == ADDR_KAX)) begin
        k_axial <= 16'(merge({16'h0, k_axial}, PWDATA, PSTRB));
      end
      if (commit & (PADDR == ADDR_KDG)) begin
        k_diag <= 16'(merge({16'h0, k_diag}, PWDATA, PSTRB));
      end
      if (commit & (PADDR == ADDR_ERR)) begin
        err_term <= 16'(merge({16'h0, err_term}, PWDATA, PSTRB));
      end else if (in_line & ~line_end) begin
        err_term <= err_term + (diag ? k_diag : k_axial);
      end
    end
  end

  // Sequencer state.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_line) begin
          next_state = ST_LINE;
        end else if (start_step) begin
          next_state = ST_STEP;
        end
      end
      ST_STEP, ST_LINE: begin
        if (op_finish) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Run counter and code index; a code's counter restarts at each new code.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state     <= ST_IDLE;
      run_cnt   <= HALF_RST;
      code_idx  <= 2'd0;
      first_pix <= 1'b0;
    end else begin
      state <= next_state;
      if (start_step) begin
        code_idx <= first_lane(PSTRB);
      end else if (in_step & code_end & ~code_stop) begin
        code_idx <= code_idx + 2'd1;
      end
      if (start_line | start_step | (pix_fire & run_end)) begin
        run_cnt <= HALF_RST;
      end else if (pix_fire) begin
        run_cnt <= run_cnt + 16'h0001;
      end
      first_pix <= (start_line | start_step) | (first_pix & ~pix_fire);
    end
  end

  // Completion flags; a finishing operation wins over a clear in that cycle.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      done_flag <= 1'b0;
      stop_flag <= 1'b0;
    end else if (start_line | start_step) begin
      done_flag <= 1'b0;
      stop_flag <= 1'b0;
    end else begin
      done_flag <= op_finish |
                   (done_flag & ~(wr_ctrl & PWDATA[CTRL_DONE_BIT]));
      stop_flag <= (op_finish & in_step & code_stop) |
                   (stop_flag & ~(wr_ctrl & PWDATA[CTRL_STOP_BIT]));
    end
  end

  // Per-map pointer movers and registers.
  generate
    for (genvar g = 0; g < NUM_MAPS; g++) begin : g_map
      vsla_ptr_step u_step (
        .x      (ptr_x[g]),
        .y      (ptr_y[g]),
        .vec    (map_vec[g]),
        .next_x (step_x[g]),
        .next_y (step_y[g])
      );

      // The mask pair is seeded from the destination at each start.
      always_ff @(posedge CLOCK) begin
        if (RESET) begin
          ptr_x[g] <= HALF_RST;
          ptr_y[g] <= HALF_RST;
        end else if ((g == MAP_MSK) && (start_line | start_step)) begin
          ptr_x[g] <= ptr_x[MAP_DST];
          ptr_y[g] <= ptr_y[MAP_DST];
        end else if (ptr_wr[g]) begin
          {ptr_y[g], ptr_x[g]} <= merge({ptr_y[g], ptr_x[g]}, PWDATA, PSTRB);
        end else if (pix_fire) begin
          ptr_x[g] <= step_x[g];
          ptr_y[g] <= step_y[g];
        end
      end

      // Addresses of the pixel being issued, held until the next one.
      always_ff @(posedge CLOCK) begin
        if (RESET) begin
          pix_x[g] <= HALF_RST;
          pix_y[g] <= HALF_RST;
        end else if (pix_fire) begin
          pix_x[g] <= ptr_x[g];
          pix_y[g] <= ptr_y[g];
        end
      end
    end
  endgenerate

  // Pixel strobe and status outputs.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      PIX_VALID <= 1'b0;
      PIX_DRAW  <= 1'b0;
      BUSY      <= 1'b0;
    end else begin
      PIX_VALID <= pix_fire;
      PIX_DRAW  <= pix_fire & pix_draw;
      BUSY      <= (next_state != ST_IDLE);
    end
  end

  // Output aliases of the pixel address registers.
  assign DST_X = pix_x[MAP_DST];
  assign DST_Y = pix_y[MAP_DST];
  assign SRC_X = pix_x[MAP_SRC];
  assign SRC_Y = pix_y[MAP_SRC];
  assign PAT_X = pix_x[MAP_PAT];
  assign PAT_Y = pix_y[MAP_PAT];
  assign MSK_X = pix_x[MAP_MSK];
  assign MSK_Y = pix_y[MAP_MSK];

endmodule

// ===== bench/vsla_top_assertions.sv
// Port checker for the vector step and line addresser, bound to its top.
module vsla_chk
  import vsla_pkg::*;
(
  // Clock and reset.
  input wire logic        CLOCK,
  input wire logic        RESET,
  // APB.
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [3:0]  PSTRB,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  // Operation and pixel stream.
  input wire logic        BUSY,
  input wire logic        PIX_VALID,
  input wire logic        PIX_DRAW,
  input wire logic [15:0] DST_X,
  input wire logic [15:0] DST_Y,
  input wire logic [15:0] SRC_X,
  input wire logic [15:0] SRC_Y,
  input wire logic [15:0] PAT_X,
  input wire logic [15:0] PAT_Y,
  input wire logic [15:0] MSK_X,
  input wire logic [15:0] MSK_Y
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_valid;
  wire  pair;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  // Deltas only mean something between two pixels of consecutive cycles.
  always_ff @(posedge CLOCK) begin
    prev_valid <= RESET ? 1'b0 : PIX_VALID;
  end
  assign pair = PIX_VALID && prev_valid;

  // Checks whether two pointers differ by at most one pixel.
  function automatic logic near(input logic [15:0] a, input logic [15:0] b);
    return 16'(a - b + 16'h1) <= 16'h2;
  endfunction

  // Bus answers and pixel stream relations.
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data not zero outside an answer");
  a_slverr_map: assert property (PREADY |->
    PSLVERR == (PADDR > ADDR_MSKXY || PADDR[1:0] != 2'b00))
    else $error("error response does not match the address");
  a_start_cause: assert property ($rose(BUSY) |-> $past(PREADY && PWRITE &&
    (PADDR == ADDR_PIXOP || (PADDR == ADDR_DSTEP && PSTRB[3]))))
    else $error("operation started without a starting write");
  a_first_pixel: assert property ($rose(BUSY) |-> ##1
    (PIX_VALID or (##1 !BUSY)))
    else $error("first pixel missing after start");
  a_pixel_busy: assert property (PIX_VALID |-> $past(BUSY))
    else $error("pixel outside an operation");
  a_draw_valid: assert property (PIX_DRAW |-> PIX_VALID)
    else $error("draw without a pixel");
  a_step_near: assert property (pair |-> near(DST_X, $past(DST_X)) &&
    near(DST_Y, $past(DST_Y)) && near(SRC_X, $past(SRC_X)) &&
    near(SRC_Y, $past(SRC_Y)))
    else $error("pointer moved beyond a neighbour");
  a_xonly_map: assert property (pair |->
    (DST_Y == $past(DST_Y) && DST_X == 16'($past(DST_X) + 16'h1)) ||
    (SRC_Y == $past(SRC_Y) && SRC_X == 16'($past(SRC_X) + 16'h1)))
    else $error("no map stepped in X only");
  a_mask_dst: assert property (PIX_VALID |-> MSK_X == DST_X &&
    MSK_Y == DST_Y)
    else $error("mask pointer differs from destination");
  a_pat_src: assert property (pair |->
    16'(PAT_X - $past(PAT_X)) == 16'(SRC_X - $past(SRC_X)) &&
    16'(PAT_Y - $past(PAT_Y)) == 16'(SRC_Y - $past(SRC_Y)))
    else $error("pattern pointer moved unlike source");

  // Main scenarios reached.
  c_start: cover property ($rose(BUSY));
  c_move_only: cover property (PIX_VALID && !PIX_DRAW);
  c_refused: cover property (PREADY && PSLVERR);
endmodule

bind vsla_top vsla_chk vsla_chk_inst (.CLOCK, .RESET, .PWRITE, .PADDR,
  .PSTRB, .PREADY, .PRDATA, .PSLVERR, .BUSY, .PIX_VALID, .PIX_DRAW, .DST_X,
  .DST_Y, .SRC_X, .SRC_Y, .PAT_X, .PAT_Y, .MSK_X, .MSK_Y);

// ===== bench/vsla_top_tb_top.sv
// Self-checking testbench of the vector step and line addresser.
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

module vsla_top_tb_top
  import vsla_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLOCK, RESET, PSEL, PENABLE, PWRITE, err;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0]  PSTRB;
  logic        PREADY, PSLVERR, BUSY, PIX_VALID, PIX_DRAW;
  logic [15:0] DST_X, DST_Y, SRC_X, SRC_Y, PAT_X, PAT_Y, MSK_X, MSK_Y;
  int          bad_count, cmp_count, npix, ndraw, p0, d0;
  int          dxt[8] = '{1, 1, 0, -1, -1, -1, 0, 1};
  int          dyt[8] = '{0, -1, -1, -1, 0, 1, 1, 1};

  vsla_top vsla_top_inst (.CLOCK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PSTRB, .PREADY, .PRDATA, .PSLVERR, .BUSY, .PIX_VALID,
    .PIX_DRAW, .DST_X, .DST_Y, .SRC_X, .SRC_Y, .PAT_X, .PAT_Y, .MSK_X,
    .MSK_Y);

  // Free-running 20 MHz clock.
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  // Pixel counter; tests compare differences so it never needs clearing.
  always @(posedge CLOCK) begin
    if (PIX_VALID === 1'b1) begin
      npix <= npix + 1;
      if (PIX_DRAW === 1'b1) ndraw <= ndraw + 1;
    end
  end

  // One APB transfer; the request holds until ready is sampled high.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge CLOCK);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    PSTRB   <= s;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1) @(posedge CLOCK);
    rd  = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Busy rises late after the commit, so a few edges pass before polling.
  // The last pixel pulse trails busy by a cycle, so one more edge lets the
  // pixel counter take it before any count is compared.
  task automatic wait_idle();
    repeat (3) @(posedge CLOCK);
    while (BUSY !== 1'b0) @(posedge CLOCK);
    @(posedge CLOCK);
  endtask

  // Start pointers; pattern starts with source, done and stop cleared.
  task automatic setp(input logic [31:0] dxy, input logic [31:0] sxy);
    xfer(1'b1, ADDR_DSTXY, dxy, 4'hf);
    xfer(1'b1, ADDR_SRCXY, sxy, 4'hf);
    xfer(1'b1, ADDR_PATXY, sxy, 4'hf);
    xfer(1'b1, ADDR_CTRL, 32'h6, 4'hf);
    p0 = npix;
    d0 = ndraw;
  endtask

  // Line parameters: error term, both constants and length.
  task automatic line_par(input logic [31:0] e, input logic [31:0] ka,
                          input logic [31:0] kd, input logic [31:0] len);
    xfer(1'b1, ADDR_ERR, e, 4'hf);
    xfer(1'b1, ADDR_KAX, ka, 4'hf);
    xfer(1'b1, ADDR_KDG, kd, 4'hf);
    xfer(1'b1, ADDR_DIM1, len, 4'hf);
  endtask

  // Starting write, then pixel counts, final pointers and status.
  task automatic op(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input int np, input int nd,
                    input logic [31:0] dxy, input logic [31:0] sxy,
                    input logic [31:0] ctl);
    xfer(1'b1, a, d, s);
    wait_idle();
    `CHK(npix - p0, np)
    `CHK(ndraw - d0, nd)
    xfer(1'b0, ADDR_DSTXY, 32'h0, 4'h0);
    `CHK(rd, dxy)
    xfer(1'b0, ADDR_SRCXY, 32'h0, 4'h0);
    `CHK(rd, sxy)
    xfer(1'b0, ADDR_PATXY, 32'h0, 4'h0);
    `CHK(rd, sxy)
    xfer(1'b0, ADDR_CTRL, 32'h0, 4'h0);
    `CHK(rd, ctl)
    $display("test ended at %0t", $time);
  endtask

  // Counts, verdict and end of run.
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog well beyond the several hundred cycles the tests need.
  initial begin
    repeat (30000) @(posedge CLOCK);
    bad_count++;
    summarize();
  end

  // Main sequence.
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
    {bad_count, cmp_count, npix, ndraw} = '0;
    RESET = 1'b1;
    repeat (8) @(posedge CLOCK);
    RESET <= 1'b0;
    xfer(1'b0, ADDR_CTRL, 32'h0, 4'h0);
    `CHK(rd, WORD_RST)
    xfer(1'b0, ADDR_PIXOP, 32'h0, 4'h0);
    `CHK(rd, PIXOP_RST)
    xfer(1'b0, 8'h2c, 32'h0, 4'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    setp(32'h000a_0011, 32'h0007_0064);
    xfer(1'b1, ADDR_PIXOP, 32'h22, 4'hf);
    wait_idle();
    `CHK(npix - p0, 0)
    op(ADDR_DSTEP, 32'h3500_0000, 4'h8, 6, 5, 32'h0005_0016,
       32'h0007_006a, 32'h2);
    setp(32'h0005_0005, 32'h0);
    xfer(1'b1, ADDR_PIXOP, 32'h2, 4'hf);
    op(ADDR_DSTEP, 32'hff00_c211, 4'hf, 5, 2, 32'h0007_0006,
       32'h0000_0005, 32'h6);
    setp(32'h0005_0005, 32'h0);
    op(ADDR_DSTEP, 32'h0000_0011, 4'h1, 0, 0, 32'h0005_0005, 32'h0,
       32'h0);
    xfer(1'b1, ADDR_PIXOP, 32'h0, 4'hf);
    op(ADDR_DSTEP, 32'h3500_0000, 4'h8, 0, 0, 32'h0005_0005, 32'h0,
       32'h0);
    xfer(1'b1, ADDR_PIXOP, 32'h2, 4'hf);
    for (int i = 0; i < 8; i++) begin
      setp(32'h0064_0064, 32'h0);
      op(ADDR_DSTEP, {i[2:0], 5'h11, 24'h0}, 4'h8, 2, 2,
         {16'(100 + dyt[i]), 16'(100 + dxt[i])}, 32'h0000_0002, 32'h2);
    end
    setp(32'h0014_000a, 32'h0032_0032);
    xfer(1'b1, ADDR_PIXOP, 32'h6, 4'hf);
    op(ADDR_DSTEP, 32'h5200_0000, 4'h8, 3, 3, 32'h0014_000d,
       32'h0030_0032, 32'h2);
    xfer(1'b0, ADDR_MSKXY, 32'h0, 4'h0);
    `CHK(rd, 32'h0014_000d)
    setp(32'h0028_0028, 32'h0);
    line_par(32'h0, 32'h4, 32'hfffc, 32'h4);
    op(ADDR_PIXOP, 32'h0421, 4'hf, 5, 4, 32'h002a_0024,
       32'h0000_0005, 32'h2);
    setp(32'h0028_0028, 32'h0);
    line_par(32'hffff, 32'h2, 32'hfffc, 32'h3);
    op(ADDR_PIXOP, 32'h0311, 4'hf, 4, 3, 32'h0025_0029,
       32'h0000_0004, 32'h2);
    summarize();
  end
endmodule
